/* core/fesp_core.sv */
// command logic for chip erase, write enable and sector protection
// How it works
// - opcodes 60h and C7h both start chip erase, no address needed.
// - chip erase runs only when the write-enable latch is already set.
// - at frame end a valid erase ignores extra bytes and self-times.
// - erase ending off a byte boundary does nothing and clears the latch.
// - any protected sector refuses chip erase and clears the latch.
// - busy shows during erase; latch cleared before erase finishes.
// - a failed erase verify sets the erase/program error flag.
// - erase and protection changes need the latch set beforehand.
// - write enable sets the latch at frame end unless erasing, extra bytes ignored.
// - write enable or disable off a byte boundary leaves the latch.
// - write disable clears the latch at frame end, extra bytes ignored.
// - one protection bit per sector; one blocks, zero permits.
// - reset sets every sector protection bit to one.
// - protect with three address bytes sets the bit, clears latch.
// - unprotect with three address bytes clears the bit, clears latch.
// - short address or off-boundary end keeps bit, clears latch.
// - lock active ignores protect and unprotect, clears the latch.
// - bytes after the three address bytes are ignored.
`timescale 1ns/1ns
module fesp_core #(
    parameter int unsigned ERASE_CYCLES = fesp_pkg::FESP_ERASE_CYCLES
) (
    input wire logic clk,                  // system clock, 100 MHz
    input wire logic sys_rst,              // reset, high; synchronous on clk, asynchronous on spi_clk
    input wire logic spi_clk,              // link clock from host
    input wire logic cs_n,                 // chip select, low active
    input wire logic si,                   // serial data in
    input wire logic protection_regs_lock, // sector bits locked
    input wire logic erase_verify_fail,    // array verify result
    output logic write_enable_latch,       // latch state
    output logic busy,                     // erase in progress
    output logic erase_program_error_flag, // last erase failed
    output logic [fesp_pkg::FESP_SECTOR_COUNT-1:0] sector_protect // bits
);
    import fesp_pkg::*;

    // ==========================================================
    // link side, on spi_clk
    // the link clock stops between frames, so a frame start is
    // marked by a flag that chip select clears while deselected
    logic link_clr;
    logic mark_reg;
    logic mark_next;
    logic first;
    logic [2:0] bit_reg;
    logic [2:0] bit_next;
    logic [2:0] nbyte_reg;
    logic [2:0] nbyte_next;
    logic [6:0] shift_reg;
    logic [6:0] shift_next;
    logic [7:0] op_reg;
    logic [7:0] op_next;
    logic [FESP_ADDR_W-1:0] addr_reg;
    logic [FESP_ADDR_W-1:0] addr_next;
    logic tog_reg;
    logic tog_next;
    logic byte_done;
    logic [7:0] byte_in;

    assign link_clr = cs_n | sys_rst;
    assign first = ~mark_reg;
    assign byte_done = ~first && (bit_reg == FESP_BIT_LAST);
    assign byte_in = {shift_reg, si};

    always_comb begin
        mark_next = 1'b1;
        tog_next = tog_reg;
        bit_next = bit_reg + 1'b1;
        nbyte_next = nbyte_reg;
        shift_next = {shift_reg[5:0], si};
        op_next = op_reg;
        addr_next = addr_reg;
        if (first) begin
            tog_next = ~tog_reg;
            bit_next = FESP_BIT_FIRST;
            nbyte_next = '0;
            shift_next = {6'h00, si};
        end else if (byte_done) begin
            if (nbyte_reg == '0) begin
                op_next = byte_in;
            end
            // bytes past the address are dropped
            if (nbyte_reg != FESP_FRAME_FULL) begin
                nbyte_next = nbyte_reg + 1'b1;
                if (nbyte_reg != '0) begin
                    addr_next = {addr_reg[15:0], byte_in};
                end
            end
        end
    end

    // frame marker: cleared to a constant while deselected
    always_ff @(posedge spi_clk or posedge link_clr) begin
        if (link_clr) begin
            mark_reg <= 1'b0;
        end else begin
            mark_reg <= mark_next;
        end
    end

    // frame toggle must start known; bit count, byte count and shift restart per frame, opcode and address hold
    always_ff @(posedge spi_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tog_reg <= 1'b0;
            bit_reg <= '0;
            nbyte_reg <= '0;
            shift_reg <= '0;
            op_reg <= '0;
            addr_reg <= '0;
        end else begin
            tog_reg <= tog_next;
            bit_reg <= bit_next;
            nbyte_reg <= nbyte_next;
            shift_reg <= shift_next;
            op_reg <= op_next;
            addr_reg <= addr_next;
        end
    end

    // ==========================================================
    // crossing into clk
    // frame words are quasi-static: spi_clk is stopped once chip
    // select is seen high here, so they are copied without sync
    logic cs_meta_reg;
    logic cs_sync_reg;
    logic cs_prev_reg;
    logic tog_meta_reg;
    logic tog_sync_reg;
    logic tog_seen_reg;
    logic tog_seen_next;
    logic frame_end;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cs_meta_reg <= FESP_CS_IDLE;
            cs_sync_reg <= FESP_CS_IDLE;
            cs_prev_reg <= FESP_CS_IDLE;
            tog_meta_reg <= 1'b0;
            tog_sync_reg <= 1'b0;
        end else begin
            cs_meta_reg <= cs_n;
            cs_sync_reg <= cs_meta_reg;
            cs_prev_reg <= cs_sync_reg;
            tog_meta_reg <= tog_reg;
            tog_sync_reg <= tog_meta_reg;
        end
    end

    assign frame_end = cs_sync_reg & ~cs_prev_reg;

    always_comb begin
        tog_seen_next = tog_seen_reg;
        if (frame_end) begin
            tog_seen_next = tog_sync_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tog_seen_reg <= 1'b0;
        end else begin
            tog_seen_reg <= tog_seen_next;
        end
    end

    // ==========================================================
    // command decode and latch control
    fesp_state_t state_reg;
    fesp_state_t state_next;
    logic latch_reg;
    logic latch_next;
    logic had_reg;
    logic had_next;
    logic [2:0] s_bit_reg;
    logic [2:0] s_bit_next;
    logic [2:0] s_nbyte_reg;
    logic [2:0] s_nbyte_next;
    logic [7:0] s_op_reg;
    logic [7:0] s_op_next;
    logic [FESP_SECTOR_IDX_W-1:0] s_sec_reg;
    logic [FESP_SECTOR_IDX_W-1:0] s_sec_next;
    logic erase_start;
    logic set_prot;
    logic clr_prot;
    logic aligned;
    logic has_op;
    logic timer_busy;
    logic [FESP_SECTOR_COUNT-1:0] prot_reg;

    assign aligned = (s_bit_reg == FESP_BIT_ALIGNED);
    assign has_op = had_reg && (s_nbyte_reg >= FESP_FRAME_OPCODE);

    always_comb begin
        state_next = state_reg;
        latch_next = latch_reg;
        had_next = had_reg;
        s_bit_next = s_bit_reg;
        s_nbyte_next = s_nbyte_reg;
        s_op_next = s_op_reg;
        s_sec_next = s_sec_reg;
        erase_start = 1'b0;
        set_prot = 1'b0;
        clr_prot = 1'b0;
        case (state_reg)
            FESP_IDLE: begin
                if (frame_end) begin
                    had_next = (tog_sync_reg != tog_seen_reg);
                    s_bit_next = bit_reg;
                    s_nbyte_next = nbyte_reg;
                    s_op_next = op_reg;
                    s_sec_next = addr_reg[FESP_SECTOR_SHIFT +:
                                          FESP_SECTOR_IDX_W];
                    state_next = FESP_DECODE;
                end
            end
            FESP_DECODE: begin
                state_next = FESP_IDLE;
                if (has_op) begin
                    case (s_op_reg)
                        FESP_OP_CHIP_ERASE_A,
                        FESP_OP_CHIP_ERASE_B: begin
                            if (!aligned) begin
                                latch_next = 1'b0;
                            end else if (!latch_reg) begin
                                latch_next = 1'b0;
                            end else if (|prot_reg) begin
                                latch_next = 1'b0;
                            end else begin
                                // latch drops as erase begins
                                latch_next = 1'b0;
                                erase_start = 1'b1;
                                state_next = FESP_ERASE;
                            end
                        end
                        FESP_OP_WRITE_ENABLE: begin
                            if (aligned) begin
                                latch_next = 1'b1;
                            end
                        end
                        FESP_OP_WRITE_DISABLE: begin
                            if (aligned) begin
                                latch_next = 1'b0;
                            end
                        end
                        FESP_OP_PROTECT,
                        FESP_OP_UNPROTECT: begin
                            latch_next = 1'b0;
                            if (latch_reg && !protection_regs_lock &&
                                aligned &&
                                s_nbyte_reg == FESP_FRAME_FULL) begin
                                set_prot = (s_op_reg == FESP_OP_PROTECT);
                                clr_prot = (s_op_reg == FESP_OP_UNPROTECT);
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            FESP_ERASE: begin
                // frames during erase are consumed and dropped
                if (!timer_busy) begin
                    state_next = FESP_IDLE;
                end
            end
            default: begin
                state_next = FESP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= FESP_IDLE;
            latch_reg <= FESP_LATCH_RESET;
            had_reg <= 1'b0;
            s_bit_reg <= '0;
            s_nbyte_reg <= '0;
            s_op_reg <= '0;
            s_sec_reg <= '0;
        end else begin
            state_reg <= state_next;
            latch_reg <= latch_next;
            had_reg <= had_next;
            s_bit_reg <= s_bit_next;
            s_nbyte_reg <= s_nbyte_next;
            s_op_reg <= s_op_next;
            s_sec_reg <= s_sec_next;
        end
    end

    // ==========================================================
    // sector protection bits, one per sector
    genvar gi;
    generate
        for (gi = 0; gi < FESP_SECTOR_COUNT; gi = gi + 1) begin : g_sec
            // each sector owns its flop, so every bit has one driver
            logic hit;
            logic p_reg;
            logic p_next;
            assign hit = (s_sec_reg == FESP_SECTOR_IDX_W'(gi));
            always_comb begin
                p_next = p_reg;
                if (set_prot && hit) begin
                    p_next = 1'b1;
                end else if (clr_prot && hit) begin
                    p_next = 1'b0;
                end
            end
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    p_reg <= FESP_SECTOR_PROT_RESET;
                end else begin
                    p_reg <= p_next;
                end
            end
            assign prot_reg[gi] = p_reg;
        end
    endgenerate

    // ==========================================================
    // erase engine
    fesp_erase_timer #(
        .ERASE_CYCLES(ERASE_CYCLES)
    ) u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(erase_start),
        .erase_verify_fail(erase_verify_fail),
        .busy(timer_busy),
        .erase_program_error_flag(erase_program_error_flag)
    );

    assign busy = timer_busy;
    assign write_enable_latch = latch_reg;
    assign sector_protect = prot_reg;

endmodule

/* core/fesp_erase_timer.sv */
// self-timed full-array erase with result check
`timescale 1ns/1ns
module fesp_erase_timer #(
    parameter int unsigned ERASE_CYCLES = fesp_pkg::FESP_ERASE_CYCLES
) (
    input wire logic clk,                // system clock
    input wire logic sys_rst,            // synchronous reset, high
    input wire logic start,              // one-cycle erase request
    input wire logic erase_verify_fail,  // array verify result
    output logic busy,                   // erase in progress
    output logic erase_program_error_flag // last erase failed
);
    import fesp_pkg::*;

    localparam logic [FESP_CNT_W-1:0] CNT_LAST =
        FESP_CNT_W'(ERASE_CYCLES - 32'd1);

    logic [FESP_CNT_W-1:0] cnt_reg;
    logic [FESP_CNT_W-1:0] cnt_next;
    logic busy_reg;
    logic busy_next;
    logic err_reg;
    logic err_next;

    // ==========================================================
    // erase sequencing
    always_comb begin
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        err_next = err_reg;
        if (busy_reg) begin
            if (cnt_reg == CNT_LAST) begin
                busy_next = 1'b0;
                // verify sampled only as the erase ends
                err_next = erase_verify_fail;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end else if (start) begin
            busy_next = 1'b1;
            cnt_next = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_reg <= '0;
            busy_reg <= 1'b0;
            err_reg <= FESP_ERR_FLAG_RESET;
        end else begin
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
            err_reg <= err_next;
        end
    end

    assign busy = busy_reg;
    assign erase_program_error_flag = err_reg;

endmodule

/* shared/fesp_pkg.sv */
// constants and types shared by the erase and sector-protect logic
package fesp_pkg;

    // ==========================================================
    // opcodes
    localparam logic [7:0] FESP_OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] FESP_OP_CHIP_ERASE_B = 8'hC7;
    localparam logic [7:0] FESP_OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] FESP_OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] FESP_OP_PROTECT = 8'h36;
    localparam logic [7:0] FESP_OP_UNPROTECT = 8'h39;

    // ==========================================================
    // frame layout: opcode byte plus three address bytes
    localparam int FESP_ADDR_W = 24;
    localparam logic [2:0] FESP_FRAME_OPCODE = 3'h1;
    localparam logic [2:0] FESP_FRAME_FULL = 3'h4;
    localparam logic [2:0] FESP_BIT_LAST = 3'h7;
    localparam logic [2:0] FESP_BIT_FIRST = 3'h1;
    localparam logic [2:0] FESP_BIT_ALIGNED = 3'h0;

    // ==========================================================
    // sectors: index taken from the upper address bits
    localparam int FESP_SECTOR_SHIFT = 16;
    localparam int FESP_SECTOR_IDX_W = 3;
    localparam int FESP_SECTOR_COUNT = 8;
    localparam logic FESP_SECTOR_PROT_RESET = 1'b1;

    // ==========================================================
    // reset values
    localparam logic FESP_LATCH_RESET = 1'b0;
    localparam logic FESP_ERR_FLAG_RESET = 1'b0;
    localparam logic FESP_CS_IDLE = 1'b1;

    // ==========================================================
    // timing
    localparam int unsigned FESP_CLK_HZ = 32'd100000000;
    localparam int unsigned FESP_ERASE_TIME_MS = 32'd4000;
    localparam int unsigned FESP_ERASE_CYCLES =
        FESP_ERASE_TIME_MS * (FESP_CLK_HZ / 32'd1000);
    localparam int FESP_CNT_W = 32;

    typedef enum logic [1:0] {
        FESP_IDLE,
        FESP_DECODE,
        FESP_ERASE
    } fesp_state_t;

endpackage

/* tb/fesp_host_model.sv */
// host spi controller model, mode 0, msb first
`timescale 1ns/1ns
module fesp_host_model (
    output logic cs_n, // chip select
    output logic spi_clk, // link clock, 32 ns period
    output logic si // serial data
);
    initial begin
        cs_n = 1'b1;
        spi_clk = 1'b0;
        si = 1'b0;
    end
    // ==========================================================
    // one frame: n bits of d, left aligned; clock stops outside
    task automatic frame(input logic [39:0] d, input int n);
        #3 cs_n = 1'b0;
        #16;
        for (int i = 0; i < n; i++) begin
            si = d[39-i];
            #16 spi_clk = 1'b1;
            #16 spi_clk = 1'b0;
        end
        #16 cs_n = 1'b1;
        // released line: no stale level
        si = ~si;
        #200;
    endtask
endmodule

/* tb/fesp_monitor.sv */
// concurrent checks on the erase and sector-protect command logic
`timescale 1ns/1ns
module fesp_monitor #(
    parameter int unsigned ERASE_CYCLES = fesp_pkg::FESP_ERASE_CYCLES
) (
    input wire logic clk, // system clock
    input wire logic sys_rst, // sync reset
    input wire logic spi_clk, // link clock
    input wire logic cs_n, // chip select
    input wire logic si, // serial data
    input wire logic protection_regs_lock, // lock input
    input wire logic erase_verify_fail, // verify result
    input wire logic write_enable_latch, // latch
    input wire logic busy, // erasing
    input wire logic erase_program_error_flag, // erase failed
    input wire logic [fesp_pkg::FESP_SECTOR_COUNT-1:0] sector_protect // bits
);
    import fesp_pkg::*;
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // busy length counter
    always_comb begin
        cnt_next = busy ? cnt_reg + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk) begin
        cnt_reg <= sys_rst ? 32'h0 : cnt_next;
    end
    // ==========================================================
    // assertions
    reset_vals_a: assert property (disable iff (1'b0) sys_rst |=>
        sector_protect == 8'hFF && !write_enable_latch && !busy)
        else $error("state not cleared by reset");
    erase_start_a: assert property ($rose(busy) |->
        $fell(write_enable_latch)) else $error("latch kept at erase");
    erase_guard_a: assert property ($rose(busy) |->
        sector_protect == 8'h00 && cs_n) else $error("erase not allowed");
    erase_len_a: assert property ($fell(busy) |->
        cnt_reg == ERASE_CYCLES) else $error("erase length wrong");
    erase_result_a: assert property ($fell(busy) |->
        erase_program_error_flag == $past(erase_verify_fail))
        else $error("error flag wrong after erase");
    flag_hold_a: assert property (!$fell(busy) |->
        $stable(erase_program_error_flag)) else $error("flag moved");
    sector_one_a: assert property ($changed(sector_protect) |->
        $onehot(sector_protect ^ $past(sector_protect))
        && $fell(write_enable_latch)) else $error("bad sector update");
    sector_lock_a: assert property ($changed(sector_protect) |->
        !protection_regs_lock) else $error("locked sector changed");
    frame_quiet_a: assert property (!cs_n [*6] |->
        $stable(write_enable_latch) && $stable(sector_protect))
        else $error("state moved inside frame");
    latch_rise_a: assert property ($rose(write_enable_latch) |->
        cs_n && $past(cs_n, 3)) else $error("latch set too early");
    cover property ($rose(busy));
    cover property ($changed(sector_protect));
    cover property ($rose(write_enable_latch));
endmodule

bind fesp_core fesp_monitor #(.ERASE_CYCLES(ERASE_CYCLES)) u_mon (
    .clk(clk), .sys_rst(sys_rst), .spi_clk(spi_clk), .cs_n(cs_n),
    .si(si), .protection_regs_lock(protection_regs_lock),
    .erase_verify_fail(erase_verify_fail),
    .write_enable_latch(write_enable_latch), .busy(busy),
    .erase_program_error_flag(erase_program_error_flag),
    .sector_protect(sector_protect)
);

/* tb/tb.sv */
// self-checking bench for the erase and sector-protect command logic
`timescale 1ns/1ns
module tb;
    import fesp_pkg::*;
    typedef struct packed {
        logic [39:0] d;
        logic [7:0] n;
        logic lk;
        logic lat;
        logic [7:0] sp;
    } fesp_row_t;
    localparam logic [39:0] WE = 40'h0600000000;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic lock = 1'b0;
    logic vfail = 1'b0;
    wire cs_n;
    wire spi_clk;
    wire si;
    wire latch;
    wire busy;
    wire err_flag;
    wire [7:0] sp;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    fesp_row_t rows [0:20] = '{
        '{WE, 8'h08, 1'b0, 1'b1, 8'hFF},
        '{40'h0400000000, 8'h07, 1'b0, 1'b1, 8'hFF},
        '{40'h04FF000000, 8'h10, 1'b0, 1'b0, 8'hFF},
        '{WE, 8'h08, 1'b0, 1'b1, 8'hFF},
        '{40'h6000000000, 8'h08, 1'b0, 1'b0, 8'hFF},
        '{WE, 8'h09, 1'b0, 1'b0, 8'hFF},
        '{WE, 8'h08, 1'b0, 1'b1, 8'hFF},
        '{40'h390B123400, 8'h20, 1'b0, 1'b0, 8'hF7},
        '{40'h3905000000, 8'h20, 1'b0, 1'b0, 8'hF7},
        '{WE, 8'h08, 1'b0, 1'b1, 8'hF7},
        '{40'h3905000000, 8'h1F, 1'b0, 1'b0, 8'hF7},
        '{WE, 8'h08, 1'b0, 1'b1, 8'hF7},
        '{40'h3905000000, 8'h20, 1'b1, 1'b0, 8'hF7},
        '{WE, 8'h08, 1'b0, 1'b1, 8'hF7},
        '{40'h3900000000, 8'h18, 1'b0, 1'b0, 8'hF7},
        '{WE, 8'h08, 1'b0, 1'b1, 8'hF7},
        '{40'h3603000000, 8'h20, 1'b0, 1'b0, 8'hFF},
        '{WE, 8'h08, 1'b0, 1'b1, 8'hFF},
        '{40'h3907FFFFA5, 8'h28, 1'b0, 1'b0, 8'h7F},
        '{WE, 8'h08, 1'b0, 1'b1, 8'h7F},
        '{40'h3607000000, 8'h20, 1'b1, 1'b0, 8'h7F}
    };

    fesp_host_model host (.cs_n(cs_n), .spi_clk(spi_clk), .si(si));
    // long erase so busy outlasts the host's frame tail
    fesp_core #(.ERASE_CYCLES(60)) dut (
        .clk(clk), .sys_rst(sys_rst), .spi_clk(spi_clk), .cs_n(cs_n),
        .si(si), .protection_regs_lock(lock), .erase_verify_fail(vfail),
        .write_enable_latch(latch), .busy(busy),
        .erase_program_error_flag(err_flag), .sector_protect(sp)
    );

    always #5 clk = ~clk;

    // ==========================================================
    // checks and closing
    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_busy(input logic v);
        int k;
        k = 0;
        while (busy !== v && k < 100) begin
            @(negedge clk);
            k++;
        end
    endtask
    task tally_and_finish;
        $display("errors=%0d checks=%0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        chk8(sp, 8'hFF);
        chk1(latch, 1'b0);
        repeat (4) @(negedge clk);
        for (int i = 0; i < 21; i++) begin
            lock = rows[i].lk;
            host.frame(rows[i].d, rows[i].n);
            @(negedge clk);
            chk1(latch, rows[i].lat);
            chk8(sp, rows[i].sp);
        end
        lock = 1'b0;
        for (int i = 0; i < 8; i++) begin
            host.frame(WE, 8);
            host.frame({8'h39, 5'h00, i[2:0], 24'h000000}, 32);
        end
        @(negedge clk);
        chk8(sp, 8'h00);
        host.frame(40'h6000000000, 8);
        @(negedge clk);
        chk1(busy, 1'b0);
        vfail = 1'b1;
        host.frame(WE, 8);
        host.frame(40'hC700000000, 12);
        @(negedge clk);
        chk1(busy, 1'b0);
        chk1(latch, 1'b0);
        host.frame(WE, 8);
        host.frame(40'h60A5000000, 16);
        wait_busy(1'b1);
        chk1(busy, 1'b1);
        chk1(latch, 1'b0);
        wait_busy(1'b0);
        chk1(err_flag, 1'b1);
        vfail = 1'b0;
        host.frame(WE, 8);
        host.frame(40'hC700000000, 8);
        wait_busy(1'b1);
        chk1(busy, 1'b1);
        wait_busy(1'b0);
        chk1(err_flag, 1'b0);
        host.frame(WE, 8);
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        chk8(sp, 8'hFF);
        chk1(latch, 1'b0);
        repeat (4) @(negedge clk);
        tally_and_finish();
    end
endmodule
